/* predistortion_map.vh */
// Constants for the predistortion actuator path
`ifndef PREDISTORTION_MAP_VH
`define PREDISTORTION_MAP_VH

// Sample and history
`define SAMPLE_W 16
`define HIST_DEPTH 16
`define HIST_IDX_W 4
`define FRAC_BITS 15

// Coefficient store
`define COEF_MAX 190
`define COEF_IDX_W 8

// Lookup tables: four banks of 256 entries
`define LUT_DEPTH 1024
`define LUT_ADDR_W 10
`define LUT_BANKS 4
`define BANK_W 2
`define LUT_IDX_W 8
`define MAX_TABLES 31

// Capture buffers
`define CAP_DEPTH 4096
`define CAP_ADDR_W 12
`define CAP_LEN_W 13
`define CAP_COUNT 3
`define CAP_PRE 2'h0
`define CAP_POST 2'h1
`define CAP_OBS 2'h2

// Interpolation select codes
`define INTERP_1X 2'h0
`define INTERP_2X 2'h1
`define INTERP_4X 2'h2

// Accumulator
`define ACC_W 40

// Actuator states
`define ST_IDLE 2'h0
`define ST_RUN 2'h1
`define ST_OUT 2'h2

`endif

/* hb_interp_stage.v */
// Half-band interpolation stage, rate one or two
`timescale 1ns/1ps
`default_nettype none
`include "predistortion_map.vh"

module hb_interp_stage (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Mode
  input wire interpEn,
  // Input stream
  input wire inValid,
  output wire inReady,
  input wire [15:0] inI,
  input wire [15:0] inQ,
  // Output stream
  output wire outValid,
  input wire outReady,
  output wire [15:0] outI,
  output wire [15:0] outQ
);

  ////////////////////////////////////////////////////////////////////////////
  reg outValid_q;
  reg [15:0] outI_q;
  reg [15:0] outQ_q;
  reg [15:0] prevI_q;
  reg [15:0] prevQ_q;
  reg [15:0] holdI_q;
  reg [15:0] holdQ_q;
  reg phase_q;
  wire advance;
  wire take;
  wire [16:0] midI;
  wire [16:0] midQ;

  assign advance = !outValid_q || outReady;
  assign inReady = advance && !phase_q;
  assign take = inValid && inReady;
  assign outValid = outValid_q;
  assign outI = outI_q;
  assign outQ = outQ_q;

  // Midpoint is the half-band odd phase with taps 1/2, 1, 1/2
  assign midI = {prevI_q[15], prevI_q} + {inI[15], inI};
  assign midQ = {prevQ_q[15], prevQ_q} + {inQ[15], inQ};

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (!resetn) begin
      outValid_q <= 1'b0;
      outI_q <= 16'h0000;
      outQ_q <= 16'h0000;
      prevI_q <= 16'h0000;
      prevQ_q <= 16'h0000;
      holdI_q <= 16'h0000;
      holdQ_q <= 16'h0000;
      phase_q <= 1'b0;
    end else if (advance) begin
      if (phase_q) begin
        // Second output of the pair, no new input taken meanwhile
        outValid_q <= 1'b1;
        outI_q <= holdI_q;
        outQ_q <= holdQ_q;
        phase_q <= 1'b0;
      end else if (take) begin
        prevI_q <= inI;
        prevQ_q <= inQ;
        outValid_q <= 1'b1;
        if (interpEn) begin
          outI_q <= midI[16:1];
          outQ_q <= midQ[16:1];
          holdI_q <= inI;
          holdQ_q <= inQ;
          phase_q <= 1'b1;
        end else begin
          outI_q <= inI;
          outQ_q <= inQ;
        end
      end else begin
        outValid_q <= 1'b0;
      end
    end
  end

endmodule // hb_interp_stage
`default_nettype wire

/* predistortion_actuator_path.v */
// Transmit predistortion path: peak reduction, interpolation, actuator, captures
`timescale 1ns/1ps
`default_nettype none
`include "predistortion_map.vh"

module predistortion_actuator_path (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Deframer samples
  input wire frmValid,
  output wire frmReady,
  input wire [15:0] frmI,
  input wire [15:0] frmQ,
  // Peak reduction
  input wire peakBypass,
  input wire [14:0] clipLevel,
  // Interpolator
  input wire [1:0] interpSel,
  // Converter chain
  output wire dacValid,
  input wire dacReady,
  output wire [15:0] dacI,
  output wire [15:0] dacQ,
  // Coefficient processor
  input wire coefWe,
  input wire [7:0] coefIdx,
  input wire [3:0] coefMem,
  input wire [3:0] coefCross,
  input wire [15:0] coefRe,
  input wire [15:0] coefIm,
  input wire lutWe,
  input wire [9:0] lutAddr,
  input wire [15:0] lutData,
  input wire commitReq,
  input wire [1:0] commitBank,
  input wire [7:0] commitCount,
  output wire commitPending,
  output wire [1:0] activeBank,
  // Observation samples
  input wire obsValid,
  input wire [15:0] obsI,
  input wire [15:0] obsQ,
  // Capture control and readout
  input wire capStart,
  input wire [12:0] capLen,
  output wire [2:0] capBusy,
  input wire [1:0] capSel,
  input wire [11:0] capAddr,
  output wire [31:0] capRdData
);

  ////////////////////////////////////////////////////////////////////////////
  // Peak reduction: hard clip per component
  function [15:0] clipComp;
    input [15:0] x;
    input [14:0] lvl;
    reg signed [16:0] xs;
    reg signed [16:0] ls;
    reg signed [16:0] ln;
    begin
      xs = {x[15], x};
      ls = {2'b00, lvl};
      ln = -ls;
      if (xs > ls)
        clipComp = ls[15:0];
      else if (xs < ln)
        clipComp = ln[15:0];
      else
        clipComp = x;
    end
  endfunction

  wire [15:0] pkI;
  wire [15:0] pkQ;
  assign pkI = peakBypass ? frmI : clipComp(frmI, clipLevel);
  assign pkQ = peakBypass ? frmQ : clipComp(frmQ, clipLevel);

  ////////////////////////////////////////////////////////////////////////////
  // Interpolator: two cascaded half-band stages
  wire hb1Valid;
  wire hb1Ready;
  wire [15:0] hb1I;
  wire [15:0] hb1Q;
  wire hbValid;
  wire hbReady;
  wire [15:0] hbI;
  wire [15:0] hbQ;
  wire firstEn;
  wire secondEn;

  assign firstEn = (interpSel != `INTERP_1X);
  assign secondEn = (interpSel == `INTERP_4X);

  hb_interp_stage firstHalfbandStage (
    .core_clk(core_clk),
    .resetn(resetn),
    .interpEn(firstEn),
    .inValid(frmValid),
    .inReady(frmReady),
    .inI(pkI),
    .inQ(pkQ),
    .outValid(hb1Valid),
    .outReady(hb1Ready),
    .outI(hb1I),
    .outQ(hb1Q)
  );

  hb_interp_stage secondHalfbandStage (
    .core_clk(core_clk),
    .resetn(resetn),
    .interpEn(secondEn),
    .inValid(hb1Valid),
    .inReady(hb1Ready),
    .inI(hb1I),
    .inQ(hb1Q),
    .outValid(hbValid),
    .outReady(hbReady),
    .outI(hbI),
    .outQ(hbQ)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Actuator storage
  reg [15:0] histI [0:`HIST_DEPTH-1];
  reg [15:0] histQ [0:`HIST_DEPTH-1];
  reg [3:0] shMem [0:`COEF_MAX-1];
  reg [3:0] shCross [0:`COEF_MAX-1];
  reg [15:0] shRe [0:`COEF_MAX-1];
  reg [15:0] shIm [0:`COEF_MAX-1];
  reg [3:0] acMem [0:`COEF_MAX-1];
  reg [3:0] acCross [0:`COEF_MAX-1];
  reg [15:0] acRe [0:`COEF_MAX-1];
  reg [15:0] acIm [0:`COEF_MAX-1];
  reg [15:0] lut [0:`LUT_DEPTH-1];
  reg [1:0] state_q;
  reg [7:0] termIdx_q;
  reg [7:0] termCount_q;
  reg [1:0] activeBank_q;
  reg commitPend_q;
  reg [1:0] pendBank_q;
  reg [7:0] pendCount_q;
  reg signed [`ACC_W-1:0] acc_q;
  reg [15:0] dacI_q;
  reg [15:0] dacQ_q;
  integer t;

  assign hbReady = (state_q == `ST_IDLE) && !commitPend_q;
  assign dacValid = (state_q == `ST_OUT);
  assign dacI = dacI_q;
  assign dacQ = dacQ_q;
  assign commitPending = commitPend_q;
  assign activeBank = activeBank_q;

  ////////////////////////////////////////////////////////////////////////////
  // One term per cycle: c * table(|u(n-i)|) * u(n-j)
  reg [15:0] mI;
  reg [15:0] mQ;
  reg [16:0] absI;
  reg [16:0] absQ;
  reg [17:0] magSum;
  reg [7:0] magIdx;
  reg signed [31:0] gReFull;
  reg signed [31:0] gImFull;
  reg signed [16:0] gRe;
  reg signed [16:0] gIm;
  reg signed [15:0] xI;
  reg signed [15:0] xQ;
  reg signed [33:0] pRe;
  reg signed [33:0] pIm;
  reg signed [`ACC_W-1:0] sumRe;
  reg signed [`ACC_W-1:0] sumIm;

  always @* begin
    mI = histI[acMem[termIdx_q]];
    mQ = histQ[acMem[termIdx_q]];
    absI = mI[15] ? (17'h00000 - {1'b1, mI}) : {1'b0, mI};
    absQ = mQ[15] ? (17'h00000 - {1'b1, mQ}) : {1'b0, mQ};
    // Cheap magnitude: max + min/2, saturated to the 8-bit table index
    magSum = (absI > absQ) ? ({1'b0, absI} + {2'b00, absQ[16:1]}) :
      ({1'b0, absQ} + {2'b00, absI[16:1]});
    magIdx = (magSum > 18'h0FFFF) ? 8'hFF : magSum[15:8];
    gReFull = $signed(acRe[termIdx_q]) * $signed(lut[{activeBank_q, magIdx}]);
    gImFull = $signed(acIm[termIdx_q]) * $signed(lut[{activeBank_q, magIdx}]);
    gRe = gReFull[31:15];
    gIm = gImFull[31:15];
    xI = histI[acCross[termIdx_q]];
    xQ = histQ[acCross[termIdx_q]];
    pRe = gRe * xI - gIm * xQ;
    pIm = gRe * xQ + gIm * xI;
    sumRe = acc_q + {{(`ACC_W-34){pRe[33]}}, pRe};
    sumIm = {{(`ACC_W-34){pIm[33]}}, pIm};
  end

  // Real part accumulates in acc_q, imaginary part in accIm_q
  reg signed [`ACC_W-1:0] accIm_q;
  wire signed [`ACC_W-1:0] sumImAll;
  assign sumImAll = accIm_q + sumIm;

  function [15:0] satOut;
    input [`ACC_W-1:0] a;
    reg signed [`ACC_W-1:0] s;
    begin
      s = $signed(a) >>> `FRAC_BITS;
      if (s > $signed(40'h0000007FFF))
        satOut = 16'h7FFF;
      else if (s < $signed(40'hFFFFFF8000))
        satOut = 16'h8000;
      else
        satOut = s[15:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Processor loads and actuator sequence
  always @(posedge core_clk) begin
    // Shadow set takes writes at any time; active set stays untouched
    if (coefWe && (coefIdx < `COEF_MAX)) begin
      shMem[coefIdx] <= coefMem;
      shCross[coefIdx] <= coefCross;
      shRe[coefIdx] <= coefRe;
      shIm[coefIdx] <= coefIm;
    end
    // Writes to the bank in use are dropped so a sample never sees a mix
    if (lutWe && (lutAddr[9:8] != activeBank_q))
      lut[lutAddr] <= lutData;
    if (state_q == `ST_IDLE && hbValid && hbReady) begin
      histI[0] <= hbI;
      histQ[0] <= hbQ;
      for (t = 1; t < `HIST_DEPTH; t = t + 1) begin
        histI[t] <= histI[t-1];
        histQ[t] <= histQ[t-1];
      end
    end
    if (resetn && state_q == `ST_IDLE && commitPend_q) begin
      for (t = 0; t < `COEF_MAX; t = t + 1) begin
        acMem[t] <= shMem[t];
        acCross[t] <= shCross[t];
        acRe[t] <= shRe[t];
        acIm[t] <= shIm[t];
      end
    end
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= `ST_IDLE;
      termIdx_q <= 8'h00;
      termCount_q <= 8'h00;
      activeBank_q <= 2'h0;
      commitPend_q <= 1'b0;
      pendBank_q <= 2'h0;
      pendCount_q <= 8'h00;
      acc_q <= 40'h0000000000;
      accIm_q <= 40'h0000000000;
      dacI_q <= 16'h0000;
      dacQ_q <= 16'h0000;
    end else begin
      if (commitReq) begin
        // Set wins over the clear by the apply in the same cycle
        commitPend_q <= 1'b1;
        pendBank_q <= commitBank;
        pendCount_q <= (commitCount > `COEF_MAX) ? 8'd`COEF_MAX : commitCount;
      end
      case (state_q)
        `ST_IDLE: begin
          if (commitPend_q) begin
            // Sample boundary: swap bank, count and coefficients together
            activeBank_q <= pendBank_q;
            termCount_q <= pendCount_q;
            if (!commitReq)
              commitPend_q <= 1'b0;
          end else if (hbValid) begin
            acc_q <= 40'h0000000000;
            accIm_q <= 40'h0000000000;
            termIdx_q <= 8'h00;
            if (termCount_q == 8'h00) begin
              dacI_q <= 16'h0000;
              dacQ_q <= 16'h0000;
              state_q <= `ST_OUT;
            end else begin
              state_q <= `ST_RUN;
            end
          end
        end
        `ST_RUN: begin
          acc_q <= sumRe;
          accIm_q <= sumImAll;
          termIdx_q <= termIdx_q + 8'h01;
          if (termIdx_q == termCount_q - 8'h01) begin
            dacI_q <= satOut(sumRe);
            dacQ_q <= satOut(sumImAll);
            state_q <= `ST_OUT;
          end
        end
        `ST_OUT: begin
          if (dacReady)
            state_q <= `ST_IDLE;
        end
        default: state_q <= `ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture buffers: pre-actuator, post-actuator, observation
  wire [2:0] capWr;
  wire [31:0] capIn [0:`CAP_COUNT-1];
  wire [12:0] capLimit;
  reg [31:0] capRd_q;

  assign capWr[0] = hbValid && hbReady;
  assign capWr[1] = dacValid && dacReady;
  assign capWr[2] = obsValid;
  assign capIn[0] = {hbI, hbQ};
  assign capIn[1] = {dacI_q, dacQ_q};
  assign capIn[2] = {obsI, obsQ};
  // Zero or oversize length means a full buffer
  assign capLimit = (capLen == 13'h0000 || capLen > `CAP_DEPTH) ? 13'h1000 : capLen;
  assign capRdData = capRd_q;

  genvar g;
  generate
    for (g = 0; g < `CAP_COUNT; g = g + 1) begin : capGen
      reg [31:0] mem [0:`CAP_DEPTH-1];
      reg [12:0] cnt_q;
      reg [12:0] lim_q;
      reg busy_q;
      assign capBusy[g] = busy_q;
      always @(posedge core_clk) begin
        if (busy_q && capWr[g])
          mem[cnt_q[11:0]] <= capIn[g];
        if (!resetn) begin
          cnt_q <= 13'h0000;
          lim_q <= 13'h1000;
          busy_q <= 1'b0;
        end else if (capStart) begin
          cnt_q <= 13'h0000;
          lim_q <= capLimit;
          busy_q <= 1'b1;
        end else if (busy_q && capWr[g]) begin
          cnt_q <= cnt_q + 13'h0001;
          if (cnt_q + 13'h0001 == lim_q)
            busy_q <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge core_clk) begin
    if (!resetn)
      capRd_q <= 32'h00000000;
    else if (capSel == `CAP_PRE)
      capRd_q <= capGen[0].mem[capAddr];
    else if (capSel == `CAP_POST)
      capRd_q <= capGen[1].mem[capAddr];
    else if (capSel == `CAP_OBS)
      capRd_q <= capGen[2].mem[capAddr];
    else
      capRd_q <= 32'h00000000;
  end

endmodule // predistortion_actuator_path
`default_nettype wire

/* predistortion_path_sva.sv */
// Port-level assertions for the predistortion actuator path
`timescale 1ns/1ps
`default_nettype none
module predistortion_path_sva (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Converter side
  input wire dacValid,
  input wire dacReady,
  input wire [15:0] dacI,
  input wire [15:0] dacQ,
  // Commit
  input wire commitReq,
  input wire [1:0] commitBank,
  input wire commitPending,
  input wire [1:0] activeBank,
  // Capture
  input wire capStart,
  input wire [12:0] capLen,
  input wire [2:0] capBusy,
  input wire obsValid
);
  reg [12:0] obsCnt_q;
  reg [12:0] len_q;
  reg [1:0] bank_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // Length zero or oversize means a full buffer
  always @(posedge core_clk) begin
    if (!resetn) begin
      obsCnt_q <= 13'h0000;
      len_q <= 13'h1000;
      bank_q <= 2'h0;
    end else begin
      if (capStart) begin
        obsCnt_q <= 13'h0000;
        len_q <= (capLen == 13'h0000 || capLen > 13'h1000) ? 13'h1000 : capLen;
      end else if (obsValid && capBusy[2]) begin
        obsCnt_q <= obsCnt_q + 13'h0001;
      end
      if (commitReq) begin
        bank_q <= commitBank;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  a_dac_hold: assert property (dacValid && !dacReady |=> dacValid && $stable(dacI) && $stable(dacQ))
    else $error("dac sample changed before taken");
  a_dac_single: assert property (dacValid && dacReady |=> !dacValid)
    else $error("dac sample repeated");
  a_commit_pend: assert property (commitReq |=> commitPending)
    else $error("commit not pending");
  a_bank_cause: assert property (activeBank != $past(activeBank) |-> $past(commitPending))
    else $error("bank changed without commit");
  a_bank_value: assert property ($fell(commitPending) |-> activeBank == bank_q)
    else $error("wrong bank applied");
  a_cap_start: assert property (capStart |=> capBusy == 3'h7)
    else $error("captures not started");
  a_cap_idle: assert property (capBusy == 3'h0 && !capStart |=> capBusy == 3'h0)
    else $error("capture started by itself");
  a_cap_len: assert property ($fell(capBusy[2]) && !$past(capStart) |-> obsCnt_q == len_q)
    else $error("capture length wrong");
  a_cap_bound: assert property (obsCnt_q <= 13'h1000)
    else $error("capture overran");
  c_commit: cover property ($fell(commitPending));
  c_stall: cover property (dacValid && !dacReady);
  c_cap_done: cover property ($fell(capBusy[2]));
endmodule // predistortion_path_sva
bind predistortion_actuator_path predistortion_path_sva predistortion_path_sva_i (
  .core_clk(core_clk), .resetn(resetn), .dacValid(dacValid), .dacReady(dacReady),
  .dacI(dacI), .dacQ(dacQ), .commitReq(commitReq), .commitBank(commitBank),
  .commitPending(commitPending), .activeBank(activeBank), .capStart(capStart),
  .capLen(capLen), .capBusy(capBusy), .obsValid(obsValid));
`default_nettype wire

/* deframer_model.sv */
// Deframer source and coefficient processor model
`timescale 1ns/1ps
`default_nettype none
module deframer_model (
  // Clock
  input wire logic core_clk,
  // Deframer stream
  output logic frmValid,
  input wire logic frmReady,
  output logic [15:0] frmI,
  output logic [15:0] frmQ,
  // Coefficient processor
  output logic coefWe,
  output logic [7:0] coefIdx,
  output logic [3:0] coefMem,
  output logic [3:0] coefCross,
  output logic [15:0] coefRe,
  output logic [15:0] coefIm,
  output logic lutWe,
  output logic [9:0] lutAddr,
  output logic [15:0] lutData,
  output logic commitReq,
  output logic [1:0] commitBank,
  output logic [7:0] commitCount
);
  initial begin
    {frmValid, coefWe, lutWe, commitReq} = 4'h0;
    {frmI, frmQ, coefIdx, coefMem, coefCross, coefRe, coefIm} = 80'h0;
    {lutAddr, lutData, commitBank, commitCount} = 36'h0;
  end
  ////////////////////////////////////////////////////////////
  // Idle lines show the inverse, so a stale sample cannot pass
  task push(input logic [15:0] i, input logic [15:0] q);
    integer k;
    begin
      @(posedge core_clk);
      frmValid <= 1'b1;
      frmI <= i;
      frmQ <= q;
      k = 0;
      do begin @(posedge core_clk); k++; end while (frmReady !== 1'b1 && k < 500);
      frmValid <= 1'b0;
      frmI <= ~i;
      frmQ <= ~q;
      if (frmReady !== 1'b1) begin
        tb.n_mismatch = tb.n_mismatch + 1;
        $display("[FAIL] frmReady exp 1 got %h", frmReady);
        tb.results;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////
  task coef(input logic [7:0] idx, input logic [15:0] re, input logic [15:0] im);
    begin
      @(posedge core_clk);
      coefWe <= 1'b1;
      {coefIdx, coefMem, coefCross, coefRe, coefIm} <= {idx, 8'h00, re, im};
      @(posedge core_clk);
      coefWe <= 1'b0;
    end
  endtask
  task lut(input logic [9:0] a, input logic [15:0] d);
    begin
      @(posedge core_clk);
      lutWe <= 1'b1;
      {lutAddr, lutData} <= {a, d};
      @(posedge core_clk);
      lutWe <= 1'b0;
    end
  endtask
  // Whole model from one bank, applied at once
  task commit(input logic [1:0] b, input logic [7:0] n);
    begin
      @(posedge core_clk);
      commitReq <= 1'b1;
      {commitBank, commitCount} <= {b, n};
      @(posedge core_clk);
      commitReq <= 1'b0;
    end
  endtask
endmodule // deframer_model
`default_nettype wire

/* tb.sv */
// Self-checking bench for the predistortion actuator path
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_mismatch++; \
$display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb;
  reg core_clk = 1'b0;
  reg resetn = 1'b0;
  reg peakBypass = 1'b1;
  reg [14:0] clipLevel = 15'h0800;
  reg [1:0] interpSel = 2'h0;
  reg dacReady = 1'b1;
  reg stall = 1'b0;
  reg obsValid = 1'b0;
  reg [15:0] obsI = 16'h0000;
  wire [15:0] obsQ = ~obsI;
  reg capStart = 1'b0;
  reg [12:0] capLen = 13'h0000;
  reg [1:0] capSel = 2'h0;
  reg [11:0] capAddr = 12'h000;
  wire frmValid, frmReady, dacValid, coefWe, lutWe, commitReq, commitPending;
  wire [15:0] frmI, frmQ, dacI, dacQ, coefRe, coefIm, lutData;
  wire [7:0] coefIdx, commitCount;
  wire [3:0] coefMem, coefCross;
  wire [9:0] lutAddr;
  wire [1:0] commitBank, activeBank;
  wire [2:0] capBusy;
  wire [31:0] capRdData;
  integer n_mismatch = 0;
  integer total_checks = 0;
  integer nObs = 0;
  reg [15:0] firstObs;
  reg [31:0] rdv;
  logic [15:0] qi[$];
  logic [15:0] qq[$];
  always #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////
  predistortion_actuator_path predistortion_actuator_path_i (
    .core_clk(core_clk), .resetn(resetn), .frmValid(frmValid), .frmReady(frmReady),
    .frmI(frmI), .frmQ(frmQ), .peakBypass(peakBypass), .clipLevel(clipLevel),
    .interpSel(interpSel), .dacValid(dacValid), .dacReady(dacReady), .dacI(dacI),
    .dacQ(dacQ), .coefWe(coefWe), .coefIdx(coefIdx), .coefMem(coefMem),
    .coefCross(coefCross), .coefRe(coefRe), .coefIm(coefIm), .lutWe(lutWe),
    .lutAddr(lutAddr), .lutData(lutData), .commitReq(commitReq), .commitBank(commitBank),
    .commitCount(commitCount), .commitPending(commitPending), .activeBank(activeBank),
    .obsValid(obsValid), .obsI(obsI), .obsQ(obsQ), .capStart(capStart),
    .capLen(capLen), .capBusy(capBusy), .capSel(capSel), .capAddr(capAddr),
    .capRdData(capRdData));
  deframer_model deframer_model_i (
    .core_clk(core_clk), .frmValid(frmValid), .frmReady(frmReady), .frmI(frmI),
    .frmQ(frmQ), .coefWe(coefWe), .coefIdx(coefIdx), .coefMem(coefMem),
    .coefCross(coefCross), .coefRe(coefRe), .coefIm(coefIm), .lutWe(lutWe),
    .lutAddr(lutAddr), .lutData(lutData), .commitReq(commitReq),
    .commitBank(commitBank), .commitCount(commitCount));
  ////////////////////////////////////////////////////////////
  // Converter sink may stall every other cycle; observation data counts up
  always @(posedge core_clk) begin
    if (dacValid === 1'b1 && dacReady === 1'b1) begin
      qi.push_back(dacI);
      qq.push_back(dacQ);
    end
    if (obsValid && capBusy[2] === 1'b1) begin
      if (nObs == 0) firstObs = obsI;
      nObs++;
    end
    dacReady <= stall ? ~dacReady : 1'b1;
    obsI <= obsI + 16'h0001;
  end
  ////////////////////////////////////////////////////////////
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task waitOut(input integer n);
    integer k;
    begin
      for (k = 0; k < 3000 && qi.size() < n; k++) @(posedge core_clk);
      if (qi.size() < n) begin n_mismatch++; $display("[FAIL] dac exp %0d got %0d", n, qi.size());
        results; end
    end
  endtask
  task waitCap(input logic [2:0] mask);
    integer k;
    begin
      for (k = 0; k < 6000 && (capBusy & mask) !== 3'h0; k++) @(posedge core_clk);
      if (k == 6000) begin n_mismatch++; $display("[FAIL] capBusy exp 0 got %h", capBusy);
        results; end
    end
  endtask
  task one(input logic [15:0] i);
    begin
      qi.delete();
      qq.delete();
      deframer_model_i.push(i, 16'h0000);
      waitOut(1);
    end
  endtask
  task commitWait(input logic [1:0] b);
    integer k;
    begin
      deframer_model_i.commit(b, 8'h01);
      // Let the pending flag settle before waiting for the apply
      #1;
      `CHK("pending", 1'b1, commitPending)
      for (k = 0; k < 300 && commitPending !== 1'b0; k++) @(posedge core_clk);
      #1;
      if (k == 300) begin n_mismatch++; $display("[FAIL] commitPending exp 0 got %h", commitPending);
        results; end
    end
  endtask
  task cap(input logic [12:0] len);
    begin
      @(posedge core_clk);
      nObs = 0;
      capLen <= len;
      capStart <= 1'b1;
      obsValid <= 1'b1;
      @(posedge core_clk);
      capStart <= 1'b0;
      // Busy bits only show after the start edge has landed
      #1;
    end
  endtask
  task rd(input logic [1:0] s);
    begin
      @(posedge core_clk);
      capSel <= s;
      capAddr <= 12'h000;
      repeat (2) @(posedge core_clk);
      #1 rdv = capRdData;
    end
  endtask
  ////////////////////////////////////////////////////////////
  task t_reset;
    begin
      #1;
      `CHK("dacValid", 1'b0, dacValid)
      `CHK("activeBank", 2'h0, activeBank)
      `CHK("capBusy", 3'h0, capBusy)
      $display("end reset");
    end
  endtask
  // Writes to the active bank must be dropped, or the output would change
  task t_terms;
    begin
      one(16'h1000);
      `CHK("zero I", 16'h0000, qi[0])
      deframer_model_i.lut(10'h110, 16'h4000);
      deframer_model_i.coef(8'h00, 16'h4000, 16'h4000);
      commitWait(2'h1);
      `CHK("bank", 2'h1, activeBank)
      deframer_model_i.lut(10'h110, 16'h7FFF);
      one(16'h1000);
      `CHK("term I", 16'h0400, qi[0])
      `CHK("term Q", 16'h0400, qq[0])
      deframer_model_i.lut(10'h210, 16'h2000);
      deframer_model_i.lut(10'h208, 16'h2000);
      commitWait(2'h2);
      one(16'h1000);
      `CHK("new I", 16'h0200, qi[0])
      @(posedge core_clk);
      peakBypass <= 1'b0;
      one(16'h1000);
      `CHK("clip Q", 16'h0100, qq[0])
      @(posedge core_clk);
      peakBypass <= 1'b1;
      $display("end terms");
    end
  endtask
  task t_interp;
    integer s;
    integer m;
    begin
      for (s = 1; s < 4; s++) begin
        m = (s == 2) ? 12 : 6;
        @(posedge core_clk);
        interpSel <= s[1:0];
        stall <= 1'b1;
        qi.delete();
        repeat (3) deframer_model_i.push(16'h1000, 16'h0000);
        waitOut(m);
        repeat (40) @(posedge core_clk);
        `CHK("outputs", m, qi.size())
        `CHK("last I", 16'h0200, qi[m - 1])
      end
      @(posedge core_clk);
      interpSel <= 2'h0;
      stall <= 1'b0;
      $display("end interp");
    end
  endtask
  task t_capture;
    begin
      cap(13'h0000);
      waitCap(3'h4);
      `CHK("obs full", 4096, nObs)
      cap(13'h0002);
      repeat (2) deframer_model_i.push(16'h1000, 16'h0000);
      waitCap(3'h7);
      `CHK("obs short", 2, nObs)
      rd(2'h0);
      `CHK("pre", 32'h10000000, rdv)
      rd(2'h1);
      `CHK("post", 32'h02000200, rdv)
      rd(2'h2);
      `CHK("obs", {firstObs, ~firstObs}, rdv)
      rd(2'h3);
      `CHK("none", 32'h00000000, rdv)
      $display("end capture");
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset;
    t_terms;
    t_interp;
    t_capture;
    results;
  end
endmodule // tb
`default_nettype wire
